// file: rtl/line_test_pattern.sv
// channel test pattern generator and detector with its control registers
// assumes path clocks and data are synchronous inputs, one bit per rising edge
//
// Overview of operation
// - rx generation clock: reference or recovered
// - tx generation clock: reference or transmit clock
// - enable field: off, prbs, arbitrary, inband
// - direction bit: 0 transmit, 1 receive
// - generator invert flips prbs and arbitrary
// - prbs selector: qrss, fifteen, eleven stage
// - detect from receive (0) or transmit (1)
// - detector invert flips data before compare
// - detector selector: qrss, 15, 11, arbitrary
// - 24-bit arbitrary pattern, bit 23 first
// - one arbitrary pattern for both ends
// - rising error insert adds one error to prbs or arbitrary, self-clears
// - counter source 111 counts detector mismatches
// - inband code repeats, bit 0 last
`timescale 1ns/10ps
module line_test_pattern (
  // system
  input wire logic sys_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clocks seen as ordinary inputs
  input wire logic local_reference_clock,
  input wire logic rx_recovered_clock,
  input wire logic transmit_clock_input,
  input wire logic tx_rz_recovered_clock,
  input wire logic tx_rz_mode,
  // path data for detection
  input wire logic rx_data_in,
  input wire logic tx_data_in,
  // generated data into the paths
  output logic tx_gen_data,
  output logic tx_gen_active,
  output logic rx_gen_data,
  output logic rx_gen_active,
  // mismatch pulse to the error counter
  output logic error_count_pulse
);
  typedef struct packed {
    logic [7:0] gen_ctrl; // pattern_gen_control
    logic [7:0] det_ctrl; // pattern_detect_control
    logic [7:0] arb_low; // arbitrary_pattern_low
    logic [7:0] arb_mid; // arbitrary_pattern_mid
    logic [7:0] arb_high; // arbitrary_pattern_high
    logic [7:0] err_ctrl; // error insert and counter source
    logic [7:0] ib_len; // inband code lengths
    logic [7:0] ib_code; // inband generation code
    logic [7:0] rdata; // read data, one cycle after the strobe
    logic err_armed; // error waits for the next generated bit
    logic [4:0] arb_idx; // generator position in the arbitrary pattern
    logic [2:0] ib_idx; // generator position in the inband code
    logic [4:0] det_idx; // detector position in the arbitrary pattern
    logic gen_bit; // last generated bit
    logic tx_data;
    logic tx_active;
    logic rx_data;
    logic rx_active;
    logic err_pulse;
  } top_state_t;
  top_state_t st, next_st;

  // clock edges
  logic ref_tick; // local reference edge
  logic rx_tick; // recovered receive clock edge
  logic tclk_tick; // transmit clock input edge
  logic rz_tick; // clock recovered from the dual rail inputs
  logic tx_tick; // transmit clock as the line mode picks it
  logic gen_tick; // generator steps on this cycle
  logic det_tick; // detector samples on this cycle
  // decoded controls
  pattern_pkg::gen_mode_t gen_mode;
  logic gen_ck, gen_pos, gen_inv, det_pos, det_inv, single_error_insert;
  logic [1:0] gen_sel, det_sel;
  logic [2:0] error_count_source, ib_top;
  logic [23:0] arbitrary_pattern;
  // generator and detector internals
  logic gen_pred, det_pred, det_bit, expected, raw_bit, out_bit;
  logic insert_now;

  // step an index down and wrap to the top
  function automatic logic [4:0] count_down(input logic [4:0] idx, input logic [4:0] top);
    count_down = (idx == 5'h00) ? top : idx - 5'h01;
  endfunction

  // pick one bit of the arbitrary pattern, guarding the index range
  function automatic logic arb_bit(input logic [23:0] pat, input logic [4:0] idx);
    arb_bit = (idx > pattern_pkg::ARB_TOP) ? 1'b0 : pat[idx];
  endfunction

  edge_strobe ref_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level_in(local_reference_clock),
    .rise(ref_tick)
  );
  edge_strobe rx_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level_in(rx_recovered_clock),
    .rise(rx_tick)
  );
  edge_strobe tclk_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level_in(transmit_clock_input),
    .rise(tclk_tick)
  );
  edge_strobe rz_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level_in(tx_rz_recovered_clock),
    .rise(rz_tick)
  );

  // field decode
  always_comb begin
    gen_ck = st.gen_ctrl[pattern_pkg::GEN_CK_BIT];
    gen_mode = pattern_pkg::gen_mode_t'(st.gen_ctrl[pattern_pkg::GEN_EN_LSB +: 2]);
    gen_pos = st.gen_ctrl[pattern_pkg::GEN_POS_BIT];
    gen_inv = st.gen_ctrl[pattern_pkg::GEN_INV_BIT];
    gen_sel = st.gen_ctrl[pattern_pkg::SEQ_SEL_LSB +: 2];
    det_pos = st.det_ctrl[pattern_pkg::DET_POS_BIT];
    det_inv = st.det_ctrl[pattern_pkg::DET_INV_BIT];
    det_sel = st.det_ctrl[pattern_pkg::SEQ_SEL_LSB +: 2];
    single_error_insert = st.err_ctrl[pattern_pkg::SINGLE_ERROR_INSERT_BIT];
    error_count_source = st.err_ctrl[pattern_pkg::ERROR_COUNT_SOURCE_LSB +: 3];
    ib_top = pattern_pkg::IB_MIN_TOP + {1'b0, st.ib_len[pattern_pkg::IB_GEN_LEN_LSB +: 2]};
    arbitrary_pattern = {st.arb_high, st.arb_mid, st.arb_low};
  end

  // clock choice for the generator and the detector
  always_comb begin
    tx_tick = tx_rz_mode ? rz_tick : tclk_tick;
    if (!gen_ck) begin
      gen_tick = ref_tick;
    end else if (gen_pos) begin
      gen_tick = rx_tick;
    end else begin
      gen_tick = tx_tick;
    end
    det_tick = det_pos ? tx_tick : rx_tick;
    det_bit = (det_pos ? tx_data_in : rx_data_in) ^ det_inv;
  end

  // generator sequence; selector only matters in prbs mode
  prbs_shift gen_shift (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .seq_sel(gen_sel),
    .shift_en(gen_tick && gen_mode == pattern_pkg::GEN_PRBS),
    .shift_bit(gen_pred),
    .predicted(gen_pred)
  );

  // detector learns the sequence from the incoming stream
  prbs_shift det_shift (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .seq_sel(det_sel),
    .shift_en(det_tick),
    .shift_bit(det_bit),
    .predicted(det_pred)
  );

  // next bit of the generator and the expected detector bit
  always_comb begin
    insert_now = 1'b0;
    case (gen_mode)
      pattern_pkg::GEN_PRBS: begin
        raw_bit = gen_pred;
        insert_now = st.err_armed;
        out_bit = raw_bit ^ gen_inv ^ insert_now;
      end
      pattern_pkg::GEN_ARB: begin
        raw_bit = arb_bit(arbitrary_pattern, st.arb_idx);
        insert_now = st.err_armed;
        out_bit = raw_bit ^ gen_inv ^ insert_now;
      end
      pattern_pkg::GEN_INBAND: begin
        raw_bit = st.ib_code[st.ib_idx];
        out_bit = raw_bit;
      end
      default: begin
        raw_bit = 1'b0;
        out_bit = 1'b0;
      end
    endcase
    if (det_sel == pattern_pkg::DET_ARB) begin
      expected = arb_bit(arbitrary_pattern, st.det_idx);
    end else begin
      expected = det_pred;
    end
  end

  // register writes, reads and pattern stepping
  always_comb begin
    next_st = st;
    next_st.err_pulse = 1'b0;
    // generator step on its clock edge
    if (gen_tick && gen_mode != pattern_pkg::GEN_OFF) begin
      next_st.gen_bit = out_bit;
      if (gen_mode == pattern_pkg::GEN_ARB) begin
        next_st.arb_idx = count_down(st.arb_idx, pattern_pkg::ARB_TOP);
      end
      if (gen_mode == pattern_pkg::GEN_INBAND) begin
        next_st.ib_idx = 3'(count_down({2'b00, st.ib_idx}, {2'b00, ib_top}));
      end
      if (insert_now) begin
        next_st.err_armed = 1'b0;
        next_st.err_ctrl[pattern_pkg::SINGLE_ERROR_INSERT_BIT] = 1'b0;
      end
    end
    // restart the arbitrary and inband positions while generation is off
    if (gen_mode == pattern_pkg::GEN_OFF) begin
      next_st.arb_idx = pattern_pkg::ARB_TOP;
      next_st.ib_idx = ib_top;
    end
    // path placement, follows the control every cycle
    next_st.tx_active = (gen_mode != pattern_pkg::GEN_OFF) && !gen_pos;
    next_st.rx_active = (gen_mode != pattern_pkg::GEN_OFF) && gen_pos;
    next_st.tx_data = next_st.tx_active ? next_st.gen_bit : 1'b0;
    next_st.rx_data = next_st.rx_active ? next_st.gen_bit : 1'b0;
    // detector compare on its clock edge
    if (det_tick) begin
      next_st.det_idx = count_down(st.det_idx, pattern_pkg::ARB_TOP);
      next_st.err_pulse = (det_bit != expected) && error_count_source == pattern_pkg::CNT_PATTERN;
    end
    // software writes; a write lands after any hardware clear
    if (reg_wr) begin
      case (reg_addr)
        pattern_pkg::OFS_GEN_CTRL: next_st.gen_ctrl = reg_wdata & pattern_pkg::MSK_GEN_CTRL;
        pattern_pkg::OFS_DET_CTRL: next_st.det_ctrl = reg_wdata & pattern_pkg::MSK_DET_CTRL;
        pattern_pkg::OFS_ARB_LOW: next_st.arb_low = reg_wdata;
        pattern_pkg::OFS_ARB_MID: next_st.arb_mid = reg_wdata;
        pattern_pkg::OFS_ARB_HIGH: next_st.arb_high = reg_wdata;
        pattern_pkg::OFS_IB_LEN: next_st.ib_len = reg_wdata & pattern_pkg::MSK_IB_LEN;
        pattern_pkg::OFS_IB_CODE: next_st.ib_code = reg_wdata;
        pattern_pkg::OFS_ERR_CTRL: begin
          next_st.err_ctrl = reg_wdata & pattern_pkg::MSK_ERR_CTRL;
          if (reg_wdata[pattern_pkg::SINGLE_ERROR_INSERT_BIT] && !single_error_insert) begin
            next_st.err_armed = 1'b1;
          end
        end
        default: begin
          next_st.err_armed = next_st.err_armed; // unmapped: ignored
        end
      endcase
    end
    // read data for the cycle after the strobe, zero elsewhere
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        pattern_pkg::OFS_GEN_CTRL: next_st.rdata = st.gen_ctrl;
        pattern_pkg::OFS_DET_CTRL: next_st.rdata = st.det_ctrl;
        pattern_pkg::OFS_ARB_LOW: next_st.rdata = st.arb_low;
        pattern_pkg::OFS_ARB_MID: next_st.rdata = st.arb_mid;
        pattern_pkg::OFS_ARB_HIGH: next_st.rdata = st.arb_high;
        pattern_pkg::OFS_IB_LEN: next_st.rdata = st.ib_len;
        pattern_pkg::OFS_IB_CODE: next_st.rdata = st.ib_code;
        pattern_pkg::OFS_ERR_CTRL: next_st.rdata = st.err_ctrl;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
      st.gen_ctrl <= pattern_pkg::RST_GEN_CTRL;
      st.det_ctrl <= pattern_pkg::RST_DET_CTRL;
      st.arb_low <= pattern_pkg::RST_ARB;
      st.arb_mid <= pattern_pkg::RST_ARB;
      st.arb_high <= pattern_pkg::RST_ARB;
      st.err_ctrl <= pattern_pkg::RST_ERR_CTRL;
      st.ib_len <= pattern_pkg::RST_IB_LEN;
      st.ib_code <= pattern_pkg::RST_IB_CODE;
      st.arb_idx <= pattern_pkg::ARB_TOP;
      st.det_idx <= pattern_pkg::ARB_TOP;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st.rdata;
  assign tx_gen_data = st.tx_data;
  assign tx_gen_active = st.tx_active;
  assign rx_gen_data = st.rx_data;
  assign rx_gen_active = st.rx_active;
  assign error_count_pulse = st.err_pulse;

  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  rx_clock_pick_a: assert property (gen_ck && gen_pos |-> gen_tick == rx_tick)
    else $error("receive generation not on recovered clock");
  tx_clock_pick_a: assert property (gen_ck && !gen_pos && tx_rz_mode |-> gen_tick == rz_tick)
    else $error("transmit generation not on rz recovered clock");
  gen_off_a: assert property (gen_mode == pattern_pkg::GEN_OFF |=> !tx_gen_active && !rx_gen_active)
    else $error("generator drives a path while off");
  gen_direction_a: assert property (gen_mode != pattern_pkg::GEN_OFF && !gen_pos && !reg_wr
      |=> tx_gen_active && !rx_gen_active)
    else $error("generator not placed on transmit path");
  arb_order_a: assert property (gen_tick && gen_mode == pattern_pkg::GEN_ARB && !st.err_armed
      && st.arb_idx == pattern_pkg::ARB_TOP |=> st.gen_bit == ($past(arbitrary_pattern[23]) ^ $past(gen_inv)))
    else $error("arbitrary pattern did not start with bit 23");
  err_clear_a: assert property (st.err_armed && gen_tick
      && (gen_mode == pattern_pkg::GEN_PRBS || gen_mode == pattern_pkg::GEN_ARB)
      && !reg_wr |=> !st.err_armed && !single_error_insert)
    else $error("error insert not cleared after insertion");
  err_source_a: assert property (error_count_pulse |-> $past(error_count_source) == pattern_pkg::CNT_PATTERN)
    else $error("mismatch counted with another counter source");
  read_back_a: assert property (reg_rd && reg_addr == pattern_pkg::OFS_DET_CTRL
      |=> reg_rdata == $past(st.det_ctrl))
    else $error("detect control read back wrong");
endmodule

// file: rtl/pattern_pkg.sv
// package: register map, field positions and codes of the channel pattern
// generator and detector; assumes an 8-bit register bus per channel
package pattern_pkg;
  // register offsets
  localparam logic [7:0] OFS_ERR_CTRL = 8'h0E;
  localparam logic [7:0] OFS_GEN_CTRL = 8'h10;
  localparam logic [7:0] OFS_DET_CTRL = 8'h11;
  localparam logic [7:0] OFS_ARB_LOW = 8'h12;
  localparam logic [7:0] OFS_ARB_MID = 8'h13;
  localparam logic [7:0] OFS_ARB_HIGH = 8'h14;
  localparam logic [7:0] OFS_IB_LEN = 8'h15;
  localparam logic [7:0] OFS_IB_CODE = 8'h16;
  // reset values
  localparam logic [7:0] RST_GEN_CTRL = 8'h00;
  localparam logic [7:0] RST_DET_CTRL = 8'h03;
  localparam logic [7:0] RST_ARB = 8'h55;
  localparam logic [7:0] RST_ERR_CTRL = 8'h00;
  localparam logic [7:0] RST_IB_LEN = 8'h01;
  localparam logic [7:0] RST_IB_CODE = 8'h01;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MSK_GEN_CTRL = 8'h7F;
  localparam logic [7:0] MSK_DET_CTRL = 8'h0F;
  localparam logic [7:0] MSK_ERR_CTRL = 8'h3C;
  localparam logic [7:0] MSK_IB_LEN = 8'h3F;
  // field positions
  localparam int GEN_CK_BIT = 6;
  localparam int GEN_EN_LSB = 4;
  localparam int GEN_POS_BIT = 3;
  localparam int GEN_INV_BIT = 2;
  localparam int SEQ_SEL_LSB = 0;
  localparam int DET_POS_BIT = 3;
  localparam int DET_INV_BIT = 2;
  localparam int SINGLE_ERROR_INSERT_BIT = 5;
  localparam int ERROR_COUNT_SOURCE_LSB = 2;
  localparam int IB_GEN_LEN_LSB = 4;
  // codes
  typedef enum logic [1:0] {
    GEN_OFF = 2'b00,
    GEN_PRBS = 2'b01,
    GEN_ARB = 2'b10,
    GEN_INBAND = 2'b11
  } gen_mode_t;
  localparam logic [1:0] SEQ_QRSS = 2'h0;
  localparam logic [1:0] SEQ_P15 = 2'h1;
  localparam logic [1:0] DET_ARB = 2'h3;
  localparam logic [2:0] CNT_PATTERN = 3'h7;
  localparam logic [4:0] ARB_TOP = 5'h17;
  localparam logic [2:0] IB_MIN_TOP = 3'h4;
  // shift register taps (zero based) and zero run limit
  localparam int QRSS_TAP_A = 19;
  localparam int QRSS_TAP_B = 16;
  localparam int P15_TAP_A = 14;
  localparam int P15_TAP_B = 13;
  localparam int P11_TAP_A = 10;
  localparam int P11_TAP_B = 8;
  localparam int QRSS_ZERO_RUN = 14;
endpackage

// file: rtl/edge_strobe.sv
// rising edge detector for a clock that arrives as an ordinary input
// assumes the input is synchronous to sys_clk and slower than half its rate
`timescale 1ns/10ps
module edge_strobe (
  // system
  input wire logic sys_clk,
  input wire logic rstn,
  // sampled level and its edge
  input wire logic level_in,
  output logic rise
);
  typedef struct packed {
    logic last; // level seen one cycle ago
  } strobe_state_t;
  strobe_state_t st, next_st;

  // remember the level; a pulse when it goes from low to high
  always_comb begin
    next_st = st;
    next_st.last = level_in;
  end

  assign rise = level_in & ~st.last;

  // register the state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: rtl/prbs_shift.sv
// pseudo-random sequence shift register with tap selection
// shift_bit is what went out (generator) or came in (checker), so the same
// logic predicts the next bit in both roles
`timescale 1ns/10ps
module prbs_shift #(
  parameter int WIDTH = 20
) (
  // system
  input wire logic sys_clk,
  input wire logic rstn,
  // sequence choice: 0 qrss, 1 fifteen stage, else eleven stage
  input wire logic [1:0] seq_sel,
  // history update
  input wire logic shift_en,
  input wire logic shift_bit,
  // bit the sequence calls for next
  output logic predicted
);
  typedef struct packed {
    logic [WIDTH-1:0] hist; // last bits of the stream, newest in bit 0
  } shift_state_t;
  shift_state_t st, next_st;
  logic raw; // feedback before zero limiting

  // pick taps; qrss forces a one after a run of zeros
  always_comb begin
    raw = 1'b0;
    predicted = 1'b0;
    case (seq_sel)
      pattern_pkg::SEQ_QRSS: begin
        raw = st.hist[pattern_pkg::QRSS_TAP_A] ^ st.hist[pattern_pkg::QRSS_TAP_B];
        predicted = raw | (st.hist[pattern_pkg::QRSS_ZERO_RUN-1:0] == '0);
      end
      pattern_pkg::SEQ_P15: begin
        predicted = st.hist[pattern_pkg::P15_TAP_A] ^ st.hist[pattern_pkg::P15_TAP_B];
      end
      default: begin
        predicted = st.hist[pattern_pkg::P11_TAP_A] ^ st.hist[pattern_pkg::P11_TAP_B];
      end
    endcase
  end

  // shift in the stream bit
  always_comb begin
    next_st = st;
    if (shift_en) begin
      next_st.hist = {st.hist[WIDTH-2:0], shift_bit};
    end
  end

  // register; all ones so the sequence starts at once
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: testbench/path_model.sv
// far side of one channel: receive and transmit data paths and the reference clock
// assumes the bench pushes bits into the queues; clocks stand still when a queue is empty
`timescale 1ns/10ps
module path_model (
  // system
  input wire logic sys_clk,
  // transmit line format, 1 = dual rail rz
  input wire logic tx_rz_mode,
  // clocks toward the block
  output logic local_reference_clock,
  output logic rx_recovered_clock,
  output logic transmit_clock_input,
  output logic tx_rz_recovered_clock,
  // path data toward the block
  output logic rx_data_in,
  output logic tx_data_in
);
  bit ref_q[$]; // one entry per reference clock period
  bit rx_q[$]; // receive bits still to send
  bit tx_q[$]; // transmit bits still to send
  logic [2:0] ph = 3'h0; // bit period of eight system cycles
  logic run_ref = 1'b0;
  logic run_rx = 1'b0;
  logic run_tx = 1'b0;

  initial begin
    local_reference_clock = 1'b0;
    rx_recovered_clock = 1'b0;
    transmit_clock_input = 1'b0;
    tx_rz_recovered_clock = 1'b0;
    rx_data_in = 1'b0;
    tx_data_in = 1'b0;
  end

  // data change while clocks are low, clocks rise mid-bit; idle lines show the inverse
  always @(posedge sys_clk) begin
    ph <= ph + 3'h1;
    if (ph == 3'h0) begin
      local_reference_clock <= 1'b0;
      rx_recovered_clock <= 1'b0;
      transmit_clock_input <= 1'b0;
      tx_rz_recovered_clock <= 1'b0;
      run_ref <= (ref_q.size() != 0);
      run_rx <= (rx_q.size() != 0);
      run_tx <= (tx_q.size() != 0);
      if (ref_q.size() != 0) void'(ref_q.pop_front());
      rx_data_in <= (rx_q.size() != 0) ? rx_q.pop_front() : ~rx_data_in;
      tx_data_in <= (tx_q.size() != 0) ? tx_q.pop_front() : ~tx_data_in;
    end else if (ph == 3'h4) begin
      local_reference_clock <= run_ref;
      rx_recovered_clock <= run_rx;
      // transmit clock comes from the nrz clock pin or from the rz rails
      transmit_clock_input <= run_tx & ~tx_rz_mode;
      tx_rz_recovered_clock <= run_tx & tx_rz_mode;
    end
  end
endmodule

// file: testbench/line_test_pattern_gen_detect_tb_top.sv
// self-checking bench of the channel pattern generator and detector
// assumes path_model on the far side and the register port on the bench
`timescale 1ns/10ps
module line_test_pattern_gen_detect_tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tx_rz_mode = 1'b0;
  logic local_reference_clock, rx_recovered_clock, transmit_clock_input, tx_rz_recovered_clock;
  logic rx_data_in, tx_data_in, tx_gen_data, tx_gen_active, rx_gen_data, rx_gen_active;
  logic error_count_pulse;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'h95f8;
  int sel = 0; // clock that times the generator: 0 reference, 1 receive, 2 transmit
  int n_err = 0; // mismatch pulses seen
  int base = 0;
  bit obs_rx = 1'b0; // watch the receive side generator output
  bit cap_on = 1'b0; // capture generated bits instead of comparing
  bit gq[$]; // expected generated bits
  bit hist[$]; // captured or composed sequence bits
  logic [7:0] rq[$]; // expected read data
  logic rd_d = 1'b0;
  logic tick_d = 1'b0;
  logic [2:0] dly = 3'h0;
  logic [7:0] cfgs[5] = '{8'h20, 8'h64, 8'h61, 8'h2E, 8'h6B};
  bit rzs[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  wire tick = (sel == 0) ? local_reference_clock :
              (sel == 1) ? rx_recovered_clock : (transmit_clock_input | tx_rz_recovered_clock);
  wire gen_bit = obs_rx ? rx_gen_data : tx_gen_data;

  line_test_pattern dut (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .local_reference_clock, .rx_recovered_clock, .transmit_clock_input, .tx_rz_recovered_clock,
    .tx_rz_mode, .rx_data_in, .tx_data_in, .tx_gen_data, .tx_gen_active, .rx_gen_data,
    .rx_gen_active, .error_count_pulse);
  path_model m (.sys_clk, .tx_rz_mode, .local_reference_clock, .rx_recovered_clock,
    .transmit_clock_input, .tx_rz_recovered_clock, .rx_data_in, .tx_data_in);

  // 250 MHz system clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
    checks_done++;
    if (exp !== got) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // the read result is compared by the watcher one cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask

  // clock periods on the path that times the generator
  task automatic ticks(int n);
    repeat (n) begin
      if (sel == 0) m.ref_q.push_back(1'b0);
      else if (sel == 1) m.rx_q.push_back(1'b0);
      else m.tx_q.push_back(1'b0);
    end
  endtask

  // bounded wait until the far side is idle and all expected bits were seen
  task automatic settle();
    for (int i = 0; i < 3000; i++) begin
      if (m.ref_q.size() + m.rx_q.size() + m.tx_q.size() + gq.size() == 0) break;
      @(posedge sys_clk);
    end
    repeat (24) @(posedge sys_clk);
    if (gq.size() != 0) chk("missing generated bits", 24'h0, 24'(gq.size()));
    gq.delete();
  endtask

  task automatic errs(int e);
    settle();
    chk("mismatch pulses", 24'(e), 24'(n_err - base));
    base = n_err;
  endtask

  task automatic send(int p, logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      if (p == 1) m.rx_q.push_back(w[i]);
      else m.tx_q.push_back(w[i]);
    end
  endtask

  // next bit of sequence s at position n of hist, with the qrss zero run limit
  function automatic bit nxt(int s, int n);
    bit b;
    bit z;
    z = 1'b1;
    if (s == 0) b = hist[n-20] ^ hist[n-17];
    else if (s == 1) b = hist[n-15] ^ hist[n-14];
    else b = hist[n-11] ^ hist[n-9];
    for (int i = 1; i <= 14; i++) z = z & ~hist[n-i];
    return (s == 0 && z) ? 1'b1 : b;
  endfunction

  // watcher: read data, generated bits after each selected clock rise, mismatch pulses
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("read data", rq.pop_front(), reg_rdata);
    tick_d <= tick;
    if (tick && !tick_d) dly <= 3'h4;
    else if (dly != 3'h0) dly <= dly - 3'h1;
    if (dly == 3'h1 && cap_on) hist.push_back(gen_bit);
    else if (dly == 3'h1 && gq.size() != 0) chk("generated bit", gq.pop_front(), gen_bit);
    if (error_count_pulse === 1'b1) n_err <= n_err + 1;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    logic [23:0] arbitrary_pattern;
    logic [7:0] code;
    do_reset();
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h03);
    rd(8'h12, 8'h55);
    rd(8'h13, 8'h55);
    rd(8'h14, 8'h55);
    wr(8'h10, 8'hFF);
    wr(8'h11, 8'hFF);
    wr(8'h20, 8'hAA);
    rd(8'h10, 8'h7F);
    rd(8'h11, 8'h0F);
    rd(8'h20, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h03);
    $display("register test done");
    // arbitrary pattern over both paths, all clock choices, invert and one inserted error
    for (int k = 0; k < 5; k++) begin
      tx_rz_mode <= rzs[k];
      arbitrary_pattern = 24'($random(seed));
      wr(8'h12, arbitrary_pattern[7:0]);
      wr(8'h13, arbitrary_pattern[15:8]);
      wr(8'h14, arbitrary_pattern[23:16]);
      if (k == 0) wr(8'h0E, 8'h20);
      sel = cfgs[k][6] ? (cfgs[k][3] ? 1 : 2) : 0;
      obs_rx = cfgs[k][3];
      for (int i = 0; i < 30; i++) gq.push_back(arbitrary_pattern[23-(i%24)] ^ cfgs[k][2] ^ (k == 0 && i == 0));
      wr(8'h10, cfgs[k]);
      repeat (2) @(posedge sys_clk);
      chk("gen active", {cfgs[k][3], ~cfgs[k][3]}, {rx_gen_active, tx_gen_active});
      ticks(30);
      settle();
      if (k == 0) rd(8'h0E, 8'h00);
      wr(8'h10, 8'h00);
    end
    $display("arbitrary generation test done");
    sel = 0;
    obs_rx = 1'b0;
    for (int len = 0; len < 4; len++) begin
      code = 8'($random(seed));
      wr(8'h15, 8'(len * 16));
      wr(8'h16, code);
      for (int i = 0; i < 2 * (5 + len); i++) gq.push_back(code[4+len-(i%(5+len))]);
      wr(8'h10, 8'h34);
      ticks(2 * (5 + len));
      settle();
      wr(8'h10, 8'h00);
    end
    $display("inband generation test done");
    for (int k = 0; k < 4; k++) begin
      hist.delete();
      cap_on = 1'b1;
      wr(8'h10, 8'(8'h10 | k));
      ticks(60);
      settle();
      wr(8'h10, 8'h00);
      cap_on = 1'b0;
      for (int i = 20; i < 60; i++) chk("prbs bit", 24'(nxt(k, i)), 24'(hist[i]));
    end
    $display("prbs generation test done");
    // detector from a fresh reset so the arbitrary index starts at the top
    do_reset();
    arbitrary_pattern = 24'($random(seed));
    wr(8'h12, arbitrary_pattern[7:0]);
    wr(8'h13, arbitrary_pattern[15:8]);
    wr(8'h14, arbitrary_pattern[23:16]);
    wr(8'h0E, 8'h1C);
    base = n_err;
    send(1, arbitrary_pattern);
    send(1, arbitrary_pattern);
    errs(0);
    wr(8'h11, 8'h0B);
    send(2, arbitrary_pattern);
    errs(0);
    wr(8'h11, 8'h0F);
    send(2, ~arbitrary_pattern);
    errs(0);
    send(2, ~arbitrary_pattern ^ 24'h000100);
    errs(1);
    wr(8'h0E, 8'h00);
    send(2, arbitrary_pattern);
    errs(0);
    wr(8'h0E, 8'h1C);
    for (int s = 0; s < 3; s++) begin
      wr(8'h11, 8'(8'h08 | s));
      hist.delete();
      for (int i = 0; i < 20; i++) hist.push_back(1'($random(seed)));
      for (int i = 20; i < 130; i++) hist.push_back(nxt(s, i));
      for (int i = 0; i < 40; i++) m.tx_q.push_back(hist[i]);
      settle();
      base = n_err;
      for (int i = 40; i < 100; i++) m.tx_q.push_back(hist[i]);
      errs(0);
      for (int i = 100; i < 130; i++) m.tx_q.push_back(hist[i] ^ (i == 110));
      settle();
      chk("prbs error seen", 24'h1, 24'(n_err != base));
      base = n_err;
    end
    $display("detection test done");
    print_verdict();
  end
endmodule
